// file: src/eil_external_interrupt_latch.sv
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/100ps
// Function
// - falling pin edge sets request latch
// - vector fetch acknowledge clears request latch
// - writing one to acknowledge clears latch
// - reset clears latch and sensitivity select
// - sensitivity select: one adds low level
// - edge mode: acknowledge clears immediately
// - level mode: needs acknowledge and pin high
// - mask blocks forwarding, latch keeps state
// - mask bit read/write, reset clears it
// - pending flag readable independent of mask
// - acknowledge bit write-only, reads zero
// - edge after acknowledge latches new request
// - taken request fetches vector at FFFA/FFFB
// - break with clear enable: acknowledge works
// - break without clear enable: acknowledge write ignored
// - pin level provided for branch instructions
module eil_external_interrupt_latch (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ext_int_pin_n,
  input  wire logic        vector_fetch_ack,
  input  wire logic        break_state,
  input  wire logic        cpu_global_mask,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  output logic             cpu_int_request,
  output logic      [15:0] vector_addr_hi,
  output logic      [15:0] vector_addr_lo,
  output logic             pin_level,
  output logic             irq_out
);

  // ---------------------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------------------
  function automatic logic reg_hit(
    input logic       strobe,
    input logic [3:0] addr,
    input logic [3:0] target
  );
    return strobe && (addr == target);
  endfunction

  // ---------------------------------------------------------------------------
  // pin synchroniser and edge detect
  // ---------------------------------------------------------------------------
  logic pin_meta_q;
  logic pin_sync_q;
  logic pin_prev_q;
  logic fall_edge;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
      pin_prev_q <= 1'b1;
    end else begin
      pin_meta_q <= ext_int_pin_n;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  // edge detect stays off until both synchroniser stages and the previous-value flop hold real pin
  // samples, so a pin already low when reset ends is not taken for a fresh falling edge
  logic [eil_pkg::SYNC_FILL_DEPTH-1:0] sync_fill_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_fill_q <= '0;
    end else begin
      sync_fill_q <= {sync_fill_q[eil_pkg::SYNC_FILL_DEPTH-2:0], 1'b1};
    end
  end

  assign fall_edge = sync_fill_q[eil_pkg::SYNC_FILL_DEPTH-1] & pin_prev_q & ~pin_sync_q;

  // ---------------------------------------------------------------------------
  // control bits
  // ---------------------------------------------------------------------------
  logic sense_level_q;
  logic req_mask_q;
  logic break_clear_enable_q;
  logic wr_ctrl;
  logic sw_ack_raw;
  logic sw_ack;

  assign wr_ctrl    = reg_hit(reg_write, reg_addr, eil_pkg::ADDR_STATUS_CONTROL);
  assign sw_ack_raw = wr_ctrl && reg_wdata[eil_pkg::BIT_ACK];
  // software acknowledge is blocked in break state unless clear enable is set
  assign sw_ack     = sw_ack_raw && (!break_state || break_clear_enable_q);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sense_level_q <= 1'b0;
      req_mask_q    <= 1'b0;
    end else if (wr_ctrl) begin
      sense_level_q <= reg_wdata[eil_pkg::BIT_SENSE];
      req_mask_q    <= reg_wdata[eil_pkg::BIT_MASK];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      break_clear_enable_q <= 1'b0;
    end else if (reg_hit(reg_write, reg_addr, eil_pkg::ADDR_BREAK_CONTROL)) begin
      break_clear_enable_q <= reg_wdata[eil_pkg::BIT_BREAK_CLEAR];
    end
  end

  // ---------------------------------------------------------------------------
  // request latch
  // ---------------------------------------------------------------------------
  logic latch_q;
  logic ack_seen_q;
  logic any_ack;
  logic vec_ack;

  // vector acknowledge only clears a latch that is set and not blocked by the request mask; the global mask is not checked
  assign vec_ack = vector_fetch_ack && latch_q && !req_mask_q;
  assign any_ack = vec_ack || sw_ack;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      latch_q    <= 1'b0;
      ack_seen_q <= 1'b0;
    end else begin
      if (fall_edge) begin
        latch_q    <= 1'b1;
        ack_seen_q <= 1'b0;
      end else if (!sense_level_q) begin
        if (any_ack) begin
          latch_q <= 1'b0;
        end
        ack_seen_q <= 1'b0;
      end else begin
        // level mode: clear once acknowledge seen and pin is back high
        if ((any_ack || ack_seen_q) && pin_sync_q) begin
          latch_q    <= 1'b0;
          ack_seen_q <= 1'b0;
        end else if (latch_q && any_ack) begin
          ack_seen_q <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // cpu side outputs
  // ---------------------------------------------------------------------------
  assign cpu_int_request = latch_q && !req_mask_q && !cpu_global_mask;
  assign vector_addr_hi  = eil_pkg::VECTOR_ADDR_HI;
  assign vector_addr_lo  = eil_pkg::VECTOR_ADDR_LO;
  assign pin_level       = pin_sync_q;

  // ---------------------------------------------------------------------------
  // event status and interrupt
  // ---------------------------------------------------------------------------
  logic [eil_pkg::EV_WIDTH-1:0] ev_status_q;
  logic [eil_pkg::EV_WIDTH-1:0] ev_mask_q;
  logic [eil_pkg::EV_WIDTH-1:0] ev_set;
  logic [eil_pkg::EV_WIDTH-1:0] ev_clr;

  always_comb begin
    ev_set                     = '0;
    ev_set[eil_pkg::EV_EDGE]   = fall_edge;
    ev_set[eil_pkg::EV_VECTOR] = vec_ack;
    ev_set[eil_pkg::EV_SW_ACK] = sw_ack;
  end

  assign ev_clr = reg_hit(reg_write, reg_addr, eil_pkg::ADDR_EVENT_STATUS) ?
                  reg_wdata[eil_pkg::EV_WIDTH-1:0] : '0;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ev_status_q <= '0;
    end else begin
      ev_status_q <= (ev_status_q & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ev_mask_q <= '0;
    end else if (reg_hit(reg_write, reg_addr, eil_pkg::ADDR_EVENT_MASK)) begin
      ev_mask_q <= reg_wdata[eil_pkg::EV_WIDTH-1:0];
    end
  end

  assign irq_out = |(ev_status_q & ev_mask_q);

  // ---------------------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= eil_pkg::REG_RESET;
    end else if (reg_read) begin
      reg_rdata <= eil_pkg::REG_RESET;
      if (reg_addr == eil_pkg::ADDR_STATUS_CONTROL) begin
        reg_rdata[eil_pkg::BIT_SENSE]   <= sense_level_q;
        reg_rdata[eil_pkg::BIT_MASK]    <= req_mask_q;
        reg_rdata[eil_pkg::BIT_ACK]     <= 1'b0;
        reg_rdata[eil_pkg::BIT_PENDING] <= latch_q;
      end else if (reg_addr == eil_pkg::ADDR_EVENT_STATUS) begin
        reg_rdata[eil_pkg::EV_WIDTH-1:0] <= ev_status_q;
      end else if (reg_addr == eil_pkg::ADDR_EVENT_MASK) begin
        reg_rdata[eil_pkg::EV_WIDTH-1:0] <= ev_mask_q;
      end else if (reg_addr == eil_pkg::ADDR_BREAK_CONTROL) begin
        reg_rdata[eil_pkg::BIT_BREAK_CLEAR] <= break_clear_enable_q;
      end
    end else begin
      reg_rdata <= eil_pkg::REG_RESET;
    end
  end

endmodule

// file: src/eil_pkg.sv
package eil_pkg;

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_EVENT_STATUS   = 4'h1;
  localparam logic [3:0] ADDR_EVENT_MASK     = 4'h2;
  localparam logic [3:0] ADDR_BREAK_CONTROL  = 4'h3;

  // ---------------------------------------------------------------------------
  // status and control field positions
  // ---------------------------------------------------------------------------
  localparam int BIT_SENSE   = 0;
  localparam int BIT_MASK    = 1;
  localparam int BIT_ACK     = 2;
  localparam int BIT_PENDING = 3;

  // event status bits
  localparam int EV_EDGE    = 0;
  localparam int EV_VECTOR  = 1;
  localparam int EV_SW_ACK  = 2;
  localparam int EV_WIDTH   = 3;

  localparam int BIT_BREAK_CLEAR = 0;

  // ---------------------------------------------------------------------------
  // pin synchroniser fill
  // ---------------------------------------------------------------------------
  localparam int SYNC_FILL_DEPTH = 3;

  // ---------------------------------------------------------------------------
  // reset values and vector
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [15:0] VECTOR_ADDR_HI = 16'hFFFA;
  localparam logic [15:0] VECTOR_ADDR_LO = 16'hFFFB;

endpackage

// file: tb/eil_monitor.sv
`timescale 1ns/100ps
module eil_monitor (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        ext_int_pin_n,
  input wire logic        vector_fetch_ack,
  input wire logic        break_state,
  input wire logic        cpu_global_mask,
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  input wire logic        cpu_int_request,
  input wire logic [15:0] vector_addr_hi,
  input wire logic [15:0] vector_addr_lo,
  input wire logic        pin_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire logic ctl_rd = reg_read && reg_addr == eil_pkg::ADDR_STATUS_CONTROL;
  wire logic sw_ack = reg_write && reg_addr == eil_pkg::ADDR_STATUS_CONTROL && reg_wdata[eil_pkg::BIT_ACK] && !break_state;
  vec_const_a: assert property (vector_addr_hi == 16'hFFFA && vector_addr_lo == 16'hFFFB)
    else $error("vector address wrong");
  glob_mask_a: assert property (cpu_global_mask |-> !cpu_int_request)
    else $error("request passed global mask");
  pin_high_a: assert property (ext_int_pin_n [*4] |-> pin_level)
    else $error("pin level not high");
  sw_ack_a: assert property (ext_int_pin_n [*5] ##0 sw_ack |=> !cpu_int_request)
    else $error("software ack did not clear");
  vec_ack_a: assert property (ext_int_pin_n [*5] ##0 vector_fetch_ack |=> !cpu_int_request)
    else $error("vector ack did not clear");
  ack_read_a: assert property (ctl_rd |=> reg_rdata[7:4] == 4'h0 && !reg_rdata[eil_pkg::BIT_ACK])
    else $error("ack or unused bits read nonzero");
  pend_read_a: assert property (ctl_rd && cpu_int_request |=> reg_rdata[eil_pkg::BIT_PENDING])
    else $error("pending flag not shown");
  mask_blk_a: assert property (ctl_rd ##1 reg_rdata[eil_pkg::BIT_MASK] |-> !$past(cpu_int_request))
    else $error("masked request forwarded");
  cover property (sw_ack);
  cover property (vector_fetch_ack && cpu_int_request);
  cover property (ctl_rd && cpu_int_request);
endmodule
bind eil_external_interrupt_latch eil_monitor mon_u (.*);

// file: tb/eil_pin_model.sv
`timescale 1ns/100ps
module eil_pin_model (
  input  wire logic clk,
  output logic      pin_n
);
  // pull-up holds the pin high until driven low
  initial pin_n = 1'b1;
  task automatic drive(input logic v);
    @(posedge clk);
    pin_n <= v;
  endtask
endmodule

// file: tb/tb.sv
`timescale 1ns/100ps
module tb;
  logic       clk, reset, pin_n, vack, brk, gmask, wr_e, rd_e, req, lvl, irq;
  logic [3:0] addr;
  logic [7:0] wd, rdata;
  int         n_errors, samples_checked;
  eil_pin_model pin_u (.clk(clk), .pin_n(pin_n));
  eil_external_interrupt_latch dut_u (.clk(clk), .reset(reset), .ext_int_pin_n(pin_n), .vector_fetch_ack(vack),
    .break_state(brk), .cpu_global_mask(gmask), .reg_addr(addr), .reg_wdata(wd), .reg_write(wr_e),
    .reg_read(rd_e), .reg_rdata(rdata), .cpu_int_request(req), .vector_addr_hi(), .vector_addr_lo(),
    .pin_level(lvl), .irq_out(irq));
  function automatic logic [7:0] ctl(logic p, logic m, logic s);
    return {4'h0, p, 1'b0, m, s};
  endfunction
  task automatic chk(logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error rdata_or_flag expected %h seen %h", e, g);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr_e <= 1'b1;
    @(posedge clk);
    wr_e <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_e <= 1'b1;
    @(posedge clk);
    rd_e <= 1'b0;
    @(negedge clk);
    chk(e, rdata);
  endtask
  task automatic edge_in;
    pin_u.drive(1'b0);
    repeat (2) @(posedge clk);
    pin_u.drive(1'b1);
    repeat (4) @(posedge clk);
  endtask
  task automatic finish_test;
    if (n_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #20000;
    n_errors++;
    finish_test();
  end
  initial begin
    logic [7:0] d;
    {reset, vack, brk, gmask, wr_e, rd_e, addr, wd} = {6'h20, 4'h0, 8'h00};
    n_errors = 0;
    samples_checked = 0;
    void'($urandom(52348));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a < 4; a++) rd(a[3:0], 8'h00);
    rd(4'hF, 8'h00);
    wr(4'h2, 8'h07);
    edge_in();
    rd(4'h0, ctl(1, 0, 0));
    chk(8'h01, {7'h00, req});
    @(posedge clk);
    gmask <= 1'b1;
    @(negedge clk);
    chk(8'h00, {7'h00, req});
    @(posedge clk);
    gmask <= 1'b0;
    wr(4'h0, 8'h02);
    rd(4'h0, ctl(1, 1, 0));
    chk(8'h00, {7'h00, req});
    wr(4'h0, 8'h04);
    rd(4'h0, ctl(0, 0, 0));
    edge_in();
    @(posedge clk);
    vack <= 1'b1;
    @(posedge clk);
    vack <= 1'b0;
    rd(4'h0, ctl(0, 0, 0));
    chk(8'h01, {7'h00, irq});
    rd(4'h1, 8'h07);
    wr(4'h1, 8'h07);
    rd(4'h1, 8'h00);
    chk(8'h00, {7'h00, irq});
    wr(4'h0, 8'h01);
    pin_u.drive(1'b0);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk(8'h00, {7'h00, lvl});
    wr(4'h0, 8'h07);
    rd(4'h0, ctl(1, 1, 1));
    pin_u.drive(1'b1);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk(8'h01, {7'h00, lvl});
    rd(4'h0, ctl(0, 1, 1));
    edge_in();
    wr(4'h0, 8'h04);
    edge_in();
    rd(4'h0, ctl(1, 0, 0));
    @(posedge clk);
    brk <= 1'b1;
    wr(4'h0, 8'h04);
    rd(4'h0, ctl(1, 0, 0));
    wr(4'h3, 8'h01);
    wr(4'h0, 8'h04);
    brk <= 1'b0;
    rd(4'h0, ctl(0, 0, 0));
    repeat (16) begin
      d = 8'($urandom);
      wr(4'h0, d & 8'hFB);
      rd(4'h0, ctl(0, d[1], d[0]));
    end
    wr(4'h0, 8'h01);
    pin_u.drive(1'b0);
    repeat (5) @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    rd(4'h0, ctl(0, 0, 0));
    repeat (4) @(posedge clk);
    rd(4'h0, ctl(0, 0, 0));
    finish_test();
  end
endmodule
